// ---- core/cprs_pkg.sv ----
// Package with constants and carriers for the core register and stack block
package cprs_pkg;

  // ---------------------------------------------------------------------------
  // Data-space register addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_INDEX_A = 8'h80;
  localparam logic [7:0] ADDR_INDEX_B = 8'h81;
  localparam logic [7:0] ADDR_SHORT_A = 8'h82;
  localparam logic [7:0] ADDR_SHORT_B = 8'h83;
  localparam logic [7:0] ADDR_ACCUM = 8'hff;

  // ---------------------------------------------------------------------------
  // Widths, depths and reset values
  // ---------------------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [11:0] RESET_VECTOR = 12'h000;

  // ---------------------------------------------------------------------------
  // Program counter update sources
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CPRS_PC_HOLD = 3'h0,
    CPRS_PC_INC = 3'h1,
    CPRS_PC_JUMP = 3'h2,
    CPRS_PC_CALL = 3'h3,
    CPRS_PC_REL = 3'h4,
    CPRS_PC_IRQ = 3'h5,
    CPRS_PC_RET = 3'h6,
    CPRS_PC_RETURN_FROM_INTERRUPT = 3'h7
  } cprs_pc_op_e;

  // Flag-pair contexts, one-hot
  typedef enum logic [2:0] {
    CPRS_CTX_NORMAL = 3'b001,
    CPRS_CTX_IRQ = 3'b010,
    CPRS_CTX_NMI = 3'b100
  } cprs_ctx_e;

  // Flag update requests from the ALU
  typedef enum logic [1:0] {
    CPRS_FL_NONE = 2'h0,
    CPRS_FL_ARITH = 2'h1,
    CPRS_FL_BTEST = 2'h2,
    CPRS_FL_ROTL = 2'h3
  } cprs_fl_op_e;

  // Program counter control from the sequencer
  typedef struct packed {
    cprs_pc_op_e op;
    logic [11:0] target;
    logic [7:0] offset;
    logic nmi;
  } cprs_pc_ctl_s;

  // ALU result for flag updates
  typedef struct packed {
    cprs_fl_op_e op;
    logic carry;
    logic [7:0] result;
    logic tested_bit;
  } cprs_alu_res_s;

  // Data-space access
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cprs_data_req_s;

  // Active flag pair
  typedef struct packed {
    logic carry;
    logic zero;
  } cprs_flags_s;

endpackage

// ---- core/cprs_stack.sv ----
// Six-level hardware return stack with shifting levels
`timescale 1ns/1ps
module cprs_stack #(
  parameter int DEPTH = cprs_pkg::STACK_DEPTH,
  parameter int WIDTH = cprs_pkg::PC_W
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic [WIDTH-1:0] top_o,
  output logic empty_o,
  output logic [3:0] level_o
);

  logic [WIDTH-1:0] lvl_ff [DEPTH];
  logic [3:0] cnt_ff;

  // ---------------------------------------------------------------------------
  // Shifting levels
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        lvl_ff[i] <= '0;
      end
    end else if (push_i) begin
      lvl_ff[0] <= push_data_i; // see [RQ16]
      for (int i = 1; i < DEPTH; i++) begin
        lvl_ff[i] <= lvl_ff[i-1]; // see [RQ16]
      end
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        lvl_ff[i] <= lvl_ff[i+1]; // see [RQ17]
      end
    end
  end

  // Occupancy saturates at both ends
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 4'h0;
    end else if (push_i && cnt_ff != 4'(DEPTH)) begin
      cnt_ff <= cnt_ff + 4'h1; // see [RQ18]
    end else if (pop_i && !push_i && cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1; // see [RQ19]
    end
  end

  assign top_o = lvl_ff[0];
  assign empty_o = (cnt_ff == 4'h0);
  assign level_o = cnt_ff;

  a_push_shift: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ16]
    push_i |=> lvl_ff[0] == $past(push_data_i) && lvl_ff[1] == $past(lvl_ff[0]))
    else $error("stack push did not shift");
  a_depth_sat: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ18]
    cnt_ff <= 4'(DEPTH))
    else $error("stack depth exceeded");

endmodule // cprs_stack

// ---- core/cprs_core_regs.sv ----
// Core register file: accumulator, pointers, program counter, flags, stack
//
// Contract
// [RQ1] 8-bit accumulator, also at data address ffh.
// [RQ2] Two index pointers at data addresses 80h and 81h.
// [RQ3] Two short-direct bytes at data addresses 82h and 83h.
// [RQ4] Program counter is 12 bits, covering 4096 program bytes.
// [RQ5] Program space above 4096 uses an external bank register, not the counter.
// [RQ6] Counter advances by one per fetched byte.
// [RQ7] Relative branch adds signed offset to counter and loads the sum.
// [RQ8] Counter loads jump/call target, interrupt vector, reset vector, or stack top.
// [RQ9] Three carry/zero pairs: normal, interrupt, non-maskable.
// [RQ10] Interrupt entry switches pair; return-from-interrupt restores previous pair.
// [RQ11] Flags kept across switches; only the active pair is accessible.
// [RQ12] Carry from arithmetic carry/borrow, bit test copy, rotate-left through carry.
// [RQ13] Zero set when latest arithmetic or logic result is zero.
// [RQ14] After reset the non-maskable context is active.
// [RQ15] Return stack: six 12-bit shifting entries, no pointer.
// [RQ16] Call or interrupt shifts entries deeper; counter enters the top.
// [RQ17] Return loads counter from top and shifts the rest up.
// [RQ18] Beyond six levels the oldest return address is lost silently.
// [RQ19] Return on empty stack stays at top; execution continues.
`timescale 1ns/1ps
module cprs_core_regs #(
  parameter int PC_WIDTH = cprs_pkg::PC_W,
  parameter logic [11:0] RESET_VEC = cprs_pkg::RESET_VECTOR
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire cprs_pkg::cprs_data_req_s data_req_i,
  input wire logic data_rd_i,
  input wire logic acc_wr_i,
  input wire logic [7:0] acc_wdata_i,
  input wire cprs_pkg::cprs_pc_ctl_s pc_ctl_i,
  input wire cprs_pkg::cprs_alu_res_s alu_res_i,
  output logic [7:0] data_rdata_o,
  output logic data_hit_o,
  output logic [11:0] pc_o,
  output logic [7:0] accumulator_o,
  output logic [7:0] index_pointer_a_o,
  output logic [7:0] index_pointer_b_o,
  output cprs_pkg::cprs_flags_s flags_o,
  output logic [2:0] context_o,
  output logic [3:0] stack_level_o
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] accumulator_ff;
  logic [7:0] index_pointer_a_ff;
  logic [7:0] index_pointer_b_ff;
  logic [7:0] short_direct_a_ff;
  logic [7:0] short_direct_b_ff;
  logic [11:0] pc_ff;
  logic [11:0] nxt_pc;
  cprs_pkg::cprs_ctx_e ctx_ff;
  cprs_pkg::cprs_ctx_e prev_ctx_ff;
  cprs_pkg::cprs_ctx_e nxt_ctx;
  logic normal_carry_ff;
  logic normal_zero_ff;
  logic interrupt_carry_ff;
  logic interrupt_zero_ff;
  logic nonmaskable_carry_ff;
  logic nonmaskable_zero_ff;
  logic [7:0] data_rdata_ff;
  logic data_hit_ff;
  logic [11:0] stack_top;
  logic stack_empty;
  logic [3:0] stack_level;
  logic push;
  logic pop;
  cprs_pkg::cprs_flags_s nxt_flags, flags_ff;
  logic nxt_carry;
  logic nxt_zero;
  logic flag_upd;

  // Address match for data-space registers
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      cprs_pkg::ADDR_INDEX_A: reg_sel = 3'h1;
      cprs_pkg::ADDR_INDEX_B: reg_sel = 3'h2;
      cprs_pkg::ADDR_SHORT_A: reg_sel = 3'h3;
      cprs_pkg::ADDR_SHORT_B: reg_sel = 3'h4;
      cprs_pkg::ADDR_ACCUM: reg_sel = 3'h5;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      accumulator_ff <= cprs_pkg::REG_RST;
    end else if (data_req_i.wr && reg_sel(data_req_i.addr) == 3'h5) begin
      accumulator_ff <= data_req_i.wdata; // see [RQ1]
    end else if (acc_wr_i) begin
      accumulator_ff <= acc_wdata_i; // see [RQ1]
    end
  end

  // ---------------------------------------------------------------------------
  // Pointer and short-direct registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      index_pointer_a_ff <= cprs_pkg::REG_RST;
      index_pointer_b_ff <= cprs_pkg::REG_RST;
      short_direct_a_ff <= cprs_pkg::REG_RST;
      short_direct_b_ff <= cprs_pkg::REG_RST;
    end else if (data_req_i.wr) begin
      case (reg_sel(data_req_i.addr))
        3'h1: index_pointer_a_ff <= data_req_i.wdata; // see [RQ2]
        3'h2: index_pointer_b_ff <= data_req_i.wdata; // see [RQ2]
        3'h3: short_direct_a_ff <= data_req_i.wdata; // see [RQ3]
        3'h4: short_direct_b_ff <= data_req_i.wdata; // see [RQ3]
        default: ;
      endcase
    end
  end

  // Registered read port, one cycle latency
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_rdata_ff <= 8'h00;
      data_hit_ff <= 1'b0;
    end else begin
      data_hit_ff <= data_rd_i && reg_sel(data_req_i.addr) != 3'h0;
      case (reg_sel(data_req_i.addr))
        3'h1: data_rdata_ff <= index_pointer_a_ff; // see [RQ2]
        3'h2: data_rdata_ff <= index_pointer_b_ff; // see [RQ2]
        3'h3: data_rdata_ff <= short_direct_a_ff; // see [RQ3]
        3'h4: data_rdata_ff <= short_direct_b_ff; // see [RQ3]
        3'h5: data_rdata_ff <= accumulator_ff; // see [RQ1]
        default: data_rdata_ff <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------------------
  // Bank switching for space above 4096 bytes lives outside this block
  always_comb begin
    nxt_pc = pc_ff;
    case (pc_ctl_i.op)
      cprs_pkg::CPRS_PC_HOLD: nxt_pc = pc_ff;
      cprs_pkg::CPRS_PC_INC: nxt_pc = pc_ff + 12'h001; // see [RQ6] [RQ4] [RQ5]
      cprs_pkg::CPRS_PC_JUMP: nxt_pc = pc_ctl_i.target; // see [RQ8]
      cprs_pkg::CPRS_PC_CALL: nxt_pc = pc_ctl_i.target; // see [RQ8]
      cprs_pkg::CPRS_PC_REL: nxt_pc = pc_ff + {{4{pc_ctl_i.offset[7]}}, pc_ctl_i.offset}; // see [RQ7]
      cprs_pkg::CPRS_PC_IRQ: nxt_pc = pc_ctl_i.target; // see [RQ8]
      cprs_pkg::CPRS_PC_RET,
      cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT: nxt_pc = stack_empty ? pc_ff : stack_top; // see [RQ8] [RQ19]
      default: nxt_pc = pc_ff;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pc_ff <= RESET_VEC; // see [RQ8]
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  assign push = pc_ctl_i.op == cprs_pkg::CPRS_PC_CALL || pc_ctl_i.op == cprs_pkg::CPRS_PC_IRQ;
  assign pop = pc_ctl_i.op == cprs_pkg::CPRS_PC_RET || pc_ctl_i.op == cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT;

  // ---------------------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------------------
  cprs_stack #(
    .DEPTH(cprs_pkg::STACK_DEPTH),
    .WIDTH(cprs_pkg::PC_W)
  ) u_stack (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .push_i(push), // see [RQ15] [RQ16]
    .pop_i(pop), // see [RQ17]
    .push_data_i(pc_ff),
    .top_o(stack_top),
    .empty_o(stack_empty),
    .level_o(stack_level)
  );

  // ---------------------------------------------------------------------------
  // Execution context
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_ctx = ctx_ff;
    if (pc_ctl_i.op == cprs_pkg::CPRS_PC_IRQ) begin
      nxt_ctx = pc_ctl_i.nmi ? cprs_pkg::CPRS_CTX_NMI : cprs_pkg::CPRS_CTX_IRQ; // see [RQ10]
    end else if (pc_ctl_i.op == cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT) begin
      nxt_ctx = prev_ctx_ff; // see [RQ10]
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctx_ff <= cprs_pkg::CPRS_CTX_NMI; // see [RQ14]
      prev_ctx_ff <= cprs_pkg::CPRS_CTX_NORMAL;
    end else begin
      case (pc_ctl_i.op)
        cprs_pkg::CPRS_PC_IRQ: prev_ctx_ff <= ctx_ff;
        cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT: prev_ctx_ff <= (ctx_ff == cprs_pkg::CPRS_CTX_NMI &&
          prev_ctx_ff == cprs_pkg::CPRS_CTX_IRQ) ? cprs_pkg::CPRS_CTX_NORMAL : prev_ctx_ff;
        default: prev_ctx_ff <= prev_ctx_ff;
      endcase
      ctx_ff <= nxt_ctx;
    end
  end

  // ---------------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------------
  always_comb begin
    flag_upd = alu_res_i.op != cprs_pkg::CPRS_FL_NONE;
    nxt_carry = flags_ff.carry;
    nxt_zero = alu_res_i.result == 8'h00; // see [RQ13]
    case (alu_res_i.op)
      cprs_pkg::CPRS_FL_ARITH: nxt_carry = alu_res_i.carry; // see [RQ12]
      cprs_pkg::CPRS_FL_BTEST: nxt_carry = alu_res_i.tested_bit; // see [RQ12]
      cprs_pkg::CPRS_FL_ROTL: nxt_carry = alu_res_i.carry; // see [RQ12]
      default: nxt_carry = flags_ff.carry;
    endcase
  end

  // Only the active pair updates; others retain their state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      normal_carry_ff <= 1'b0;
      normal_zero_ff <= 1'b0;
      interrupt_carry_ff <= 1'b0;
      interrupt_zero_ff <= 1'b0;
      nonmaskable_carry_ff <= 1'b0;
      nonmaskable_zero_ff <= 1'b0;
    end else if (flag_upd) begin
      case (ctx_ff)
        cprs_pkg::CPRS_CTX_NORMAL: begin
          normal_carry_ff <= nxt_carry; // see [RQ9] [RQ11]
          normal_zero_ff <= nxt_zero;
        end
        cprs_pkg::CPRS_CTX_IRQ: begin
          interrupt_carry_ff <= nxt_carry; // see [RQ9] [RQ11]
          interrupt_zero_ff <= nxt_zero;
        end
        cprs_pkg::CPRS_CTX_NMI: begin
          nonmaskable_carry_ff <= nxt_carry; // see [RQ9] [RQ11]
          nonmaskable_zero_ff <= nxt_zero;
        end
        default: ;
      endcase
    end
  end

  // Pair active after this edge, registered for the output
  always_comb begin
    case (nxt_ctx)
      cprs_pkg::CPRS_CTX_NORMAL: nxt_flags = {normal_carry_ff, normal_zero_ff};
      cprs_pkg::CPRS_CTX_IRQ: nxt_flags = {interrupt_carry_ff, interrupt_zero_ff};
      cprs_pkg::CPRS_CTX_NMI: nxt_flags = {nonmaskable_carry_ff, nonmaskable_zero_ff};
      default: nxt_flags = '0;
    endcase
    if (flag_upd && nxt_ctx == ctx_ff) begin
      nxt_flags = {nxt_carry, nxt_zero}; // see [RQ11]
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags; // see [RQ10] [RQ11]
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign data_rdata_o = data_rdata_ff;
  assign data_hit_o = data_hit_ff;
  assign pc_o = pc_ff;
  assign accumulator_o = accumulator_ff;
  assign index_pointer_a_o = index_pointer_a_ff;
  assign index_pointer_b_o = index_pointer_b_ff;
  assign context_o = ctx_ff;
  assign stack_level_o = stack_level;
  assign flags_o = flags_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_acc_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ1]
    data_req_i.wr && data_req_i.addr == cprs_pkg::ADDR_ACCUM |=>
    accumulator_ff == $past(data_req_i.wdata))
    else $error("accumulator not written at its address");
  a_ptr_read: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ2]
    data_rd_i && data_req_i.addr == cprs_pkg::ADDR_INDEX_B |=>
    data_hit_ff && data_rdata_ff == $past(index_pointer_b_ff))
    else $error("pointer b read wrong");
  a_short_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ3]
    data_req_i.wr && data_req_i.addr == cprs_pkg::ADDR_SHORT_A |=>
    short_direct_a_ff == $past(data_req_i.wdata))
    else $error("short direct a not written");
  a_pc_inc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ6]
    pc_ctl_i.op == cprs_pkg::CPRS_PC_INC |=> pc_ff == $past(pc_ff) + 12'h001)
    else $error("counter did not advance by one");
  a_pc_rel: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ7]
    pc_ctl_i.op == cprs_pkg::CPRS_PC_REL |=>
    pc_ff == $past(pc_ff) + {{4{$past(pc_ctl_i.offset[7])}}, $past(pc_ctl_i.offset)})
    else $error("relative branch sum wrong");
  a_call_ret: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ16]
    pc_ctl_i.op == cprs_pkg::CPRS_PC_CALL ##1 pc_ctl_i.op == cprs_pkg::CPRS_PC_RET |=>
    pc_ff == $past(pc_ff, 2))
    else $error("return did not restore call address");
  a_reset_ctx: assert property (@(posedge clock_i) // see [RQ14]
    $past(sys_rst_i) && !sys_rst_i |-> ctx_ff == cprs_pkg::CPRS_CTX_NMI && pc_ff == RESET_VEC)
    else $error("reset context or vector wrong");
  a_irq_ctx: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ10]
    pc_ctl_i.op == cprs_pkg::CPRS_PC_IRQ && !pc_ctl_i.nmi ##1
    pc_ctl_i.op == cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT |=> ctx_ff == $past(ctx_ff, 2))
    else $error("context not restored after interrupt return");
  a_zero_flag: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ13]
    alu_res_i.op == cprs_pkg::CPRS_FL_ARITH && pc_ctl_i.op == cprs_pkg::CPRS_PC_HOLD |=>
    flags_o.zero == ($past(alu_res_i.result) == 8'h00))
    else $error("zero flag wrong");
  a_flag_keep: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see [RQ11]
    ctx_ff != cprs_pkg::CPRS_CTX_NORMAL |=> $stable(normal_carry_ff))
    else $error("inactive flag pair changed");

endmodule // cprs_core_regs

// ---- tb/testbench.sv ----
// Self-checking testbench for the core register and stack block
`timescale 1ns/1ps
`define CMP(act, exp) begin n_compared++; if ((act) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module testbench;
  typedef struct {int due; int sel; logic [11:0] val;} cprs_note_s;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  cprs_pkg::cprs_data_req_s data_req_i;
  cprs_pkg::cprs_pc_ctl_s pc_ctl_i;
  cprs_pkg::cprs_alu_res_s alu_res_i;
  cprs_pkg::cprs_flags_s flags_o;
  logic data_rd_i, acc_wr_i, data_hit_o;
  logic [7:0] acc_wdata_i, data_rdata_o, accumulator_o, index_pointer_a_o, index_pointer_b_o;
  logic [11:0] pc_o, mpc;
  logic [2:0] context_o, mctx;
  logic [3:0] stack_level_o;
  logic [11:0] mstk[$];
  logic [2:0] mcq[$];
  logic [1:0] mfl[3];
  logic [7:0] mem[logic [7:0]];
  logic [7:0] addrs[5];
  cprs_note_s notes[$];
  int cyc = 0;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h00015271;

  cprs_core_regs i_cprs_core_regs (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .data_req_i(data_req_i), .data_rd_i(data_rd_i), .acc_wr_i(acc_wr_i),
    .acc_wdata_i(acc_wdata_i), .pc_ctl_i(pc_ctl_i), .alu_res_i(alu_res_i),
    .data_rdata_o(data_rdata_o), .data_hit_o(data_hit_o), .pc_o(pc_o),
    .accumulator_o(accumulator_o), .index_pointer_a_o(index_pointer_a_o),
    .index_pointer_b_o(index_pointer_b_o), .flags_o(flags_o), .context_o(context_o),
    .stack_level_o(stack_level_o));

  initial begin
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] actual(input int sel);
    case (sel)
      0: return {4'h0, data_rdata_o};
      1: return {11'h000, data_hit_o};
      2: return pc_o;
      3: return {4'h0, accumulator_o};
      4: return {4'h0, index_pointer_a_o};
      5: return {4'h0, index_pointer_b_o};
      6: return {10'h000, flags_o.carry, flags_o.zero};
      7: return {9'h000, context_o};
      default: return {8'h00, stack_level_o};
    endcase
  endfunction
  function automatic int fi();
    return (mctx == cprs_pkg::CPRS_CTX_NMI) ? 2 : (mctx == cprs_pkg::CPRS_CTX_IRQ) ? 1 : 0;
  endfunction
  task automatic note(input int d, input int sel, input logic [11:0] v);
    notes.push_back('{cyc + d, sel, v});
  endtask
  task automatic note_state(input int d);
    note(d, 2, mpc);
    note(d, 6, {10'h000, mfl[fi()]});
    note(d, 7, {9'h000, mctx});
    note(d, 8, 12'(mstk.size()));
  endtask
  task automatic note_regs();
    note(1, 3, {4'h0, mem[cprs_pkg::ADDR_ACCUM]});
    note(1, 4, {4'h0, mem[cprs_pkg::ADDR_INDEX_A]});
    note(1, 5, {4'h0, mem[cprs_pkg::ADDR_INDEX_B]});
  endtask
  task automatic go(input cprs_pkg::cprs_data_req_s dq = '0, input logic rd = 1'b0,
                    input logic aw = 1'b0, input logic [7:0] ad = 8'h00,
                    input cprs_pkg::cprs_pc_ctl_s pc = '0,
                    input cprs_pkg::cprs_alu_res_s al = '0);
    @(posedge clock_i);
    #1;
    data_req_i = dq;
    data_rd_i = rd;
    acc_wr_i = aw;
    acc_wdata_i = ad;
    pc_ctl_i = pc;
    alu_res_i = al;
  endtask

  // ---------------------------------------------------------------------------
  // Drivers, each noting what should appear
  // ---------------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cprs_pkg::cprs_data_req_s q;
    q = '{1'b1, a, d};
    go(.dq(q));
    if (mem.exists(a)) mem[a] = d;
    note_regs();
  endtask
  task automatic rd_reg(input logic [7:0] a);
    cprs_pkg::cprs_data_req_s q;
    q = '{1'b0, a, 8'h00};
    go(.dq(q), .rd(1'b1));
    note(1, 0, mem.exists(a) ? {4'h0, mem[a]} : 12'h000);
    note(1, 1, {11'h000, mem.exists(a)});
  endtask
  task automatic acc_wr(input logic [7:0] d, input logic both);
    cprs_pkg::cprs_data_req_s q;
    q = '{both, cprs_pkg::ADDR_ACCUM, ~d};
    go(.dq(q), .aw(1'b1), .ad(d));
    mem[cprs_pkg::ADDR_ACCUM] = both ? ~d : d;
    note_regs();
  endtask
  task automatic pc_op(input cprs_pkg::cprs_pc_op_e op, input logic [11:0] tgt,
                       input logic [7:0] ofs, input logic nmi);
    cprs_pkg::cprs_pc_ctl_s p;
    p = '{op, tgt, ofs, nmi};
    go(.pc(p));
    case (op)
      cprs_pkg::CPRS_PC_INC: mpc = mpc + 12'h001;
      cprs_pkg::CPRS_PC_JUMP: mpc = tgt;
      cprs_pkg::CPRS_PC_REL: mpc = mpc + {{4{ofs[7]}}, ofs};
      cprs_pkg::CPRS_PC_CALL, cprs_pkg::CPRS_PC_IRQ: begin
        mstk.push_front(mpc);
        if (mstk.size() > cprs_pkg::STACK_DEPTH) void'(mstk.pop_back());
        mpc = tgt;
      end
      cprs_pkg::CPRS_PC_RET, cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT: begin
        if (mstk.size() > 0) mpc = mstk.pop_front();
      end
      default: ;
    endcase
    if (op == cprs_pkg::CPRS_PC_IRQ) begin
      mcq.push_back(mctx);
      mctx = nmi ? cprs_pkg::CPRS_CTX_NMI : cprs_pkg::CPRS_CTX_IRQ;
    end
    if (op == cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT) begin
      mctx = (mcq.size() > 0) ? mcq.pop_back() : cprs_pkg::CPRS_CTX_NORMAL;
    end
    note_state(1);
  endtask
  task automatic alu_op(input cprs_pkg::cprs_fl_op_e op, input logic c, input logic [7:0] r,
                        input logic tb);
    cprs_pkg::cprs_alu_res_s q;
    q = '{op, c, r, tb};
    go(.al(q));
    if (op != cprs_pkg::CPRS_FL_NONE) begin
      mfl[fi()][0] = (r == 8'h00);
      mfl[fi()][1] = (op == cprs_pkg::CPRS_FL_BTEST) ? tb : c;
    end
    note_state(1);
  endtask

  // ---------------------------------------------------------------------------
  // Output monitor
  // ---------------------------------------------------------------------------
  always @(negedge clock_i) begin
    cprs_note_s h;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      h = notes.pop_front();
      `CMP(actual(h.sel), h.val)
    end
  end

  task automatic complete_run();
    if (notes.size() > 0) mismatches++;
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(3000 * 40);
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    data_req_i = '0;
    data_rd_i = 1'b0;
    acc_wr_i = 1'b0;
    acc_wdata_i = 8'h00;
    pc_ctl_i = '0;
    alu_res_i = '0;
    addrs = '{cprs_pkg::ADDR_INDEX_A, cprs_pkg::ADDR_INDEX_B, cprs_pkg::ADDR_SHORT_A,
              cprs_pkg::ADDR_SHORT_B, cprs_pkg::ADDR_ACCUM};
    foreach (addrs[i]) mem[addrs[i]] = cprs_pkg::REG_RST;
    mfl = '{2'b00, 2'b00, 2'b00};
    mpc = cprs_pkg::RESET_VECTOR;
    mctx = cprs_pkg::CPRS_CTX_NMI;
    repeat (6) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    note_state(0);
    $display("test reset done");
    foreach (addrs[i]) rd_reg(addrs[i]);
    foreach (addrs[i]) wr_reg(addrs[i], rnd());
    foreach (addrs[i]) rd_reg(addrs[i]);
    wr_reg(8'h84, rnd());
    rd_reg(8'h00);
    rd_reg(8'h84);
    rd_reg(8'hfe);
    acc_wr(rnd(), 1'b0);
    acc_wr(rnd(), 1'b1);
    rd_reg(cprs_pkg::ADDR_ACCUM);
    $display("test data space done");
    alu_op(cprs_pkg::CPRS_FL_ARITH, 1'b1, 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 1'b0);
    alu_op(cprs_pkg::CPRS_FL_ROTL, 1'b1, 8'h80, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_IRQ, 12'h010, 8'h00, 1'b0);
    alu_op(cprs_pkg::CPRS_FL_BTEST, 1'b0, 8'h00, 1'b1);
    pc_op(cprs_pkg::CPRS_PC_IRQ, 12'h020, 8'h00, 1'b1);
    alu_op(cprs_pkg::CPRS_FL_ARITH, 1'b0, 8'h03, 1'b1);
    alu_op(cprs_pkg::CPRS_FL_NONE, 1'b1, 8'h00, 1'b1);
    pc_op(cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_IRQ, 12'h030, 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 1'b0);
    $display("test flags done");
    pc_op(cprs_pkg::CPRS_PC_JUMP, 12'(rnd()), 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_INC, 12'h000, 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_REL, 12'h000, 8'hfc, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_REL, 12'h000, 8'h05, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_JUMP, 12'hfff, 8'h00, 1'b0);
    pc_op(cprs_pkg::CPRS_PC_INC, 12'h000, 8'h00, 1'b0);
    repeat (7) pc_op(cprs_pkg::CPRS_PC_CALL, 12'(rnd()), 8'h00, 1'b0);
    repeat (8) pc_op(cprs_pkg::CPRS_PC_RET, 12'h000, 8'h00, 1'b0);
    $display("test program counter and stack done");
    repeat (3) go();
    complete_run();
  end
endmodule // testbench
